/* File: clock_mode_ctrl.sv */
// system clock selection, low-power modes and wake-up control
`timescale 1ns/10ps
`default_nettype none
`include "clock_mode_params.svh"

module clock_mode_ctrl #(
  parameter int CNT_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // cpu events
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic sub_keep_on,
  // oscillators
  input wire clock_mode_pkg::osc_option_type osc_option,
  input wire logic high_osc_tick,
  input wire logic low_osc_tick,
  // clock tree and interrupt
  output clock_mode_pkg::clock_ctrl_type clock_ctrl,
  output clock_mode_pkg::power_state_type power_state,
  output logic irq
);

  import clock_mode_pkg::*;

  // ==========================================================
  // declarations
  logic [2:0] div_sel_reg;
  logic fast_wake_enable_reg;
  logic idle_select_reg;
  logic high_low_clock_select_reg;
  logic idle_clock_keep_reg;
  logic [`IRQ_W-1:0] irq_status_reg;
  logic [`IRQ_W-1:0] irq_mask_reg;
  logic [`IRQ_W-1:0] irq_event;
  power_state_type state_reg;
  power_state_type state_next;
  logic fast_wake_reg;
  logic on_low_reg;
  logic high_osc_ready_flag;
  logic low_osc_ready_flag;
  logic high_ready_d_reg;
  logic low_ready_d_reg;
  logic wake_done;
  logic want_low;
  logic need_high;
  logic high_on;
  logic low_on;
  logic target_ready;
  logic fast_ok;
  logic [CNT_W-1:0] high_settle;
  logic [CNT_W-1:0] low_settle;
  clock_ctrl_type ctrl_next;
  logic [7:0] mode_ctrl_value;

  generate
    if (CNT_W > 16) begin : g_check
      $error("clock_mode_ctrl: CNT_W above 16 is not supported");
    end
  endgenerate

  // ==========================================================
  // register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      div_sel_reg <= 3'(`MODE_CTRL_RESET >> `DIV_SEL_LO);
      fast_wake_enable_reg <= 1'(`MODE_CTRL_RESET >> `FAST_WAKE_BIT);
      idle_select_reg <= 1'(`MODE_CTRL_RESET >> `IDLE_SEL_BIT);
      high_low_clock_select_reg <= 1'(`MODE_CTRL_RESET >> `HL_SEL_BIT);
    end else if (reg_wr && reg_addr == `ADDR_MODE_CTRL) begin
      // ready bits 3..2 are not stored here
      div_sel_reg <= reg_wdata[`DIV_SEL_HI:`DIV_SEL_LO];
      fast_wake_enable_reg <= reg_wdata[`FAST_WAKE_BIT];
      idle_select_reg <= reg_wdata[`IDLE_SEL_BIT];
      high_low_clock_select_reg <= reg_wdata[`HL_SEL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      idle_clock_keep_reg <= `AUX_CTRL_RESET;
    end else if (reg_wr && reg_addr == `ADDR_AUX_CTRL) begin
      idle_clock_keep_reg <= reg_wdata[`AUX_KEEP_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask_reg <= `IRQ_RESET;
    end else if (reg_wr && reg_addr == `ADDR_IRQ_MASK) begin
      irq_mask_reg <= reg_wdata[`IRQ_W-1:0];
    end
  end

  // ==========================================================
  // sticky interrupt status, set wins over clear
  assign irq_event[`IRQ_HIGH_READY] = high_osc_ready_flag && !high_ready_d_reg;
  assign irq_event[`IRQ_LOW_READY] = low_osc_ready_flag && !low_ready_d_reg;
  assign irq_event[`IRQ_WAKE_DONE] = wake_done;

  always_ff @(posedge clk) begin
    if (rst) begin
      high_ready_d_reg <= 1'b0;
      low_ready_d_reg <= 1'b0;
    end else begin
      high_ready_d_reg <= high_osc_ready_flag;
      low_ready_d_reg <= low_osc_ready_flag;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status_reg <= `IRQ_RESET;
    end else if (reg_wr && reg_addr == `ADDR_IRQ_STATUS) begin
      irq_status_reg <= (irq_status_reg & ~reg_wdata[`IRQ_W-1:0]) | irq_event;
    end else begin
      irq_status_reg <= irq_status_reg | irq_event;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_status_reg | irq_event) & irq_mask_reg);
    end
  end

  // ==========================================================
  // register reads
  always_comb begin
    mode_ctrl_value = {div_sel_reg, fast_wake_enable_reg,
                       low_osc_ready_flag, high_osc_ready_flag,
                       idle_select_reg, high_low_clock_select_reg};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_MODE_CTRL: reg_rdata <= mode_ctrl_value;
        `ADDR_IRQ_STATUS: reg_rdata <= {5'h00, irq_status_reg};
        `ADDR_IRQ_MASK: reg_rdata <= {5'h00, irq_mask_reg};
        `ADDR_AUX_CTRL: reg_rdata <= {7'h00, idle_clock_keep_reg};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // clock choice
  assign want_low = !high_low_clock_select_reg &&
                    (div_sel_reg == `DIV_LOW_A ||
                     div_sel_reg == `DIV_LOW_B);

  // active source follows the request once the new oscillator is ready
  always_ff @(posedge clk) begin
    if (rst) begin
      on_low_reg <= 1'b0;
    end else if (state_reg == st_run) begin
      if (want_low && low_osc_ready_flag) begin
        on_low_reg <= 1'b1;
      end else if (!want_low && high_osc_ready_flag) begin
        on_low_reg <= 1'b0;
      end
    end
  end

  // high oscillator runs only while the system may use it
  always_comb begin
    need_high = !want_low || !on_low_reg;
    case (state_reg)
      st_run: high_on = need_high;
      st_idle_1_mode: high_on = need_high;
      st_wake: high_on = need_high;
      default: high_on = 1'b0;
    endcase
  end

  assign low_on = (state_reg != st_sleep_0_mode);

  // ==========================================================
  // stabilisation counters
  always_comb begin
    case (osc_option.high_kind)
      high_speed_crystal: high_settle = CNT_W'(`CRYSTAL_SETTLE);
      default: high_settle = CNT_W'(`HIGH_RC_SETTLE);
    endcase
    case (osc_option.low_kind)
      low_speed_crystal: low_settle = CNT_W'(`CRYSTAL_SETTLE);
      default: low_settle = CNT_W'(`LOW_RC_SETTLE);
    endcase
  end

  osc_ready_counter #(
    .CNT_W(CNT_W)
  ) u_high_ready (
    .clk(clk),
    .rst(rst),
    .osc_on(high_on),
    .osc_tick(high_osc_tick),
    .settle_count(high_settle),
    .ready(high_osc_ready_flag)
  );

  osc_ready_counter #(
    .CNT_W(CNT_W)
  ) u_low_ready (
    .clk(clk),
    .rst(rst),
    .osc_on(low_on),
    .osc_tick(low_osc_tick),
    .settle_count(low_settle),
    .ready(low_osc_ready_flag)
  );

  // ==========================================================
  // power mode sequencing
  assign target_ready = on_low_reg ? low_osc_ready_flag : high_osc_ready_flag;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_run: begin
        if (halt_req) begin
          if (!idle_select_reg) begin
            state_next = sub_keep_on ? st_sleep_1_mode
                                     : st_sleep_0_mode;
          end else if (idle_clock_keep_reg) begin
            state_next = st_idle_1_mode;
          end else begin
            state_next = st_idle_0_mode;
          end
        end
      end
      st_sleep_0_mode, st_sleep_1_mode, st_idle_0_mode: begin
        if (wake_req) begin
          state_next = st_wake;
        end
      end
      st_idle_1_mode: begin
        if (wake_req) begin
          state_next = st_run;
        end
      end
      st_wake: begin
        if (target_ready) begin
          state_next = st_run;
        end
      end
      default: state_next = st_run;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= st_run;
    end else begin
      state_reg <= state_next;
    end
  end

  // fast wake decided at the wake event from the mode being left
  assign fast_ok = fast_wake_enable_reg && !on_low_reg &&
                   osc_option.high_kind == high_speed_crystal &&
                   (state_reg == st_sleep_1_mode ||
                    state_reg == st_idle_0_mode);

  always_ff @(posedge clk) begin
    if (rst) begin
      fast_wake_reg <= 1'b0;
    end else if (wake_req && state_next == st_wake) begin
      fast_wake_reg <= fast_ok;
    end else if (state_reg != st_wake) begin
      fast_wake_reg <= 1'b0;
    end
  end

  assign wake_done = (state_reg == st_wake) && target_ready;

  // ==========================================================
  // clock tree outputs
  always_comb begin
    ctrl_next.div_code = div_sel_reg;
    ctrl_next.high_osc_enable = high_on;
    ctrl_next.low_osc_enable = low_on;
    ctrl_next.periph_div_run = high_on && high_osc_ready_flag;
    ctrl_next.cpu_run = 1'b0;
    if (on_low_reg) begin
      ctrl_next.src = src_low;
    end else if (high_low_clock_select_reg || want_low) begin
      ctrl_next.src = src_high;
    end else begin
      ctrl_next.src = src_high_div;
    end
    case (state_reg)
      st_run: ctrl_next.cpu_run = 1'b1;
      st_idle_1_mode: ctrl_next.cpu_run = 1'b0;
      st_wake: begin
        if (fast_wake_reg && low_osc_ready_flag && !target_ready) begin
          ctrl_next.src = src_low;
          ctrl_next.cpu_run = 1'b1;
        end else begin
          ctrl_next.src = src_off;
        end
      end
      default: ctrl_next.src = src_off;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clock_ctrl <= '0;
    end else begin
      clock_ctrl <= ctrl_next;
    end
  end

  assign power_state = state_reg;

endmodule

`default_nettype wire

/* File: clock_mode_params.svh */
// constants for the system clock mode and wake-up controller
`ifndef CLOCK_MODE_PARAMS_SVH
`define CLOCK_MODE_PARAMS_SVH

// ==========================================================
// register map
`define ADDR_MODE_CTRL 2'h0
`define ADDR_IRQ_STATUS 2'h1
`define ADDR_IRQ_MASK 2'h2
`define ADDR_AUX_CTRL 2'h3

// ==========================================================
// mode control field layout
`define MODE_CTRL_RESET 8'h03
`define DIV_SEL_HI 7
`define DIV_SEL_LO 5
`define FAST_WAKE_BIT 4
`define LOW_READY_BIT 3
`define HIGH_READY_BIT 2
`define IDLE_SEL_BIT 1
`define HL_SEL_BIT 0
`define WRITABLE_MASK 8'hf3

// ==========================================================
// aux control and interrupt layout
`define AUX_CTRL_RESET 1'h0
`define AUX_KEEP_BIT 0
`define IRQ_W 3
`define IRQ_RESET 3'h0
`define IRQ_HIGH_READY 0
`define IRQ_LOW_READY 1
`define IRQ_WAKE_DONE 2

// ==========================================================
// divider codes
`define DIV_LOW_A 3'h0
`define DIV_LOW_B 3'h1

// ==========================================================
// stabilisation counts in oscillator cycles
`define CRYSTAL_SETTLE 12'h400
`define HIGH_RC_SETTLE 12'h010
`define LOW_RC_SETTLE 12'h002

`endif

/* File: clock_mode_pkg.sv */
// types for the system clock mode and wake-up controller
package clock_mode_pkg;

  // ==========================================================
  // power modes
  typedef enum logic [2:0] {
    st_run,
    st_sleep_0_mode,
    st_sleep_1_mode,
    st_idle_0_mode,
    st_idle_1_mode,
    st_wake
  } power_state_type;

  // ==========================================================
  // oscillator option straps
  typedef enum logic [1:0] {
    high_speed_crystal,
    external_rc,
    high_speed_internal_rc
  } high_osc_kind_type;

  typedef enum logic {
    low_speed_crystal,
    low_speed_internal_rc
  } low_osc_kind_type;

  typedef enum logic [1:0] {
    src_off,
    src_high,
    src_high_div,
    src_low
  } sys_src_type;

  typedef struct packed {
    high_osc_kind_type high_kind;
    low_osc_kind_type low_kind;
  } osc_option_type;

  // ==========================================================
  // clock tree controls
  typedef struct packed {
    sys_src_type src;
    logic [2:0] div_code;
    logic high_osc_enable;
    logic low_osc_enable;
    logic cpu_run;
    logic periph_div_run;
  } clock_ctrl_type;

endpackage

/* File: osc_ready_counter.sv */
// counts oscillator cycles after start-up and flags stability
`timescale 1ns/10ps
`default_nettype none

module osc_ready_counter #(
  parameter int CNT_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // oscillator
  input wire logic osc_on,
  input wire logic osc_tick,
  input wire logic [CNT_W-1:0] settle_count,
  // status
  output logic ready
);

  logic [CNT_W-1:0] count_reg;

  generate
    if (CNT_W < 11) begin : g_check
      $error("osc_ready_counter: CNT_W too small for crystal count");
    end
  endgenerate

  // restart from zero whenever the oscillator is stopped
  always_ff @(posedge clk) begin
    if (rst || !osc_on) begin
      count_reg <= '0;
    end else if (osc_tick && count_reg != settle_count) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !osc_on) begin
      ready <= 1'b0;
    end else begin
      ready <= (count_reg == settle_count);
    end
  end

endmodule

`default_nettype wire

/* File: clock_mode_ctrl_props.sv */
// assertion checker for the clock mode controller
`timescale 1ns/10ps
`default_nettype none
`include "clock_mode_params.svh"
module clock_mode_ctrl_props
  import clock_mode_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // cpu events
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic sub_keep_on,
  // oscillators
  input wire clock_mode_pkg::osc_option_type osc_option,
  input wire logic high_osc_tick,
  input wire logic low_osc_tick,
  // clock tree and interrupt
  input wire clock_mode_pkg::clock_ctrl_type clock_ctrl,
  input wire clock_mode_pkg::power_state_type power_state,
  input wire logic irq
);
  import clock_mode_pkg::*;
  logic [7:0] mode_reg;
  logic keep_reg;
  logic from_s0_reg;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ====
  // shadow of the software-visible settings
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= `MODE_CTRL_RESET;
      keep_reg <= 1'h0;
    end else if (reg_wr && reg_addr == `ADDR_MODE_CTRL) begin
      mode_reg <= reg_wdata;
    end else if (reg_wr && reg_addr == `ADDR_AUX_CTRL) begin
      keep_reg <= reg_wdata[0];
    end
  end
  always_ff @(posedge clk) begin
    if (rst || power_state == st_run) from_s0_reg <= 1'h0;
    else if (power_state == st_sleep_0_mode) from_s0_reg <= 1'h1;
  end
  // ====
  // properties
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
  property p_halt_idle;
    halt_req && power_state == st_run && mode_reg[1] |=>
      power_state == (keep_reg ? st_idle_1_mode : st_idle_0_mode);
  endproperty
  a_halt_idle: assert property (p_halt_idle)
    else $error("halt did not enter idle");
  property p_halt_sleep;
    halt_req && power_state == st_run && !mode_reg[1] |=> power_state ==
      ($past(sub_keep_on) ? st_sleep_1_mode : st_sleep_0_mode);
  endproperty
  a_halt_sleep: assert property (p_halt_sleep)
    else $error("halt did not enter sleep");
  property p_idle_0_mode_stop;
    power_state == st_idle_0_mode && $past(power_state) == st_idle_0_mode
      |-> clock_ctrl.src == src_off && !clock_ctrl.cpu_run;
  endproperty
  a_idle_0_mode_stop: assert property (p_idle_0_mode_stop)
    else $error("idle-0 clock running");
  property p_low_sleep_0_mode;
    (power_state == st_sleep_0_mode) [*4] ##0 (reg_rd && reg_addr == 2'h0)
      |=> !reg_rdata[`LOW_READY_BIT];
  endproperty
  a_low_sleep_0_mode: assert property (p_low_sleep_0_mode)
    else $error("low ready set in sleep-0");
  property p_high_down;
    (power_state inside {st_sleep_0_mode, st_sleep_1_mode, st_idle_0_mode})
      [*4] ##0 (reg_rd && reg_addr == 2'h0) |=> !reg_rdata[`HIGH_READY_BIT];
  endproperty
  a_high_down: assert property (p_high_down)
    else $error("high ready set while stopped");
  property p_src_hl;
    power_state == st_run && $past(power_state) == st_run && mode_reg[0]
      && $past(mode_reg[0]) && !$past(rst)
      |-> clock_ctrl.src inside {src_high, src_low};
  endproperty
  a_src_hl: assert property (p_src_hl) else $error("divided clock with hl set");
  property p_div;
    clock_ctrl.src == src_high_div |-> !$past(mode_reg[0]) &&
      clock_ctrl.div_code == $past(mode_reg[7:5]) && clock_ctrl.div_code > 3'h1;
  endproperty
  a_div: assert property (p_div) else $error("divider code mismatch");
  property p_low_off;
    (power_state == st_run && clock_ctrl.src == src_low && !mode_reg[0]
      && mode_reg[7:6] == 2'h0) [*3] |->
      !clock_ctrl.high_osc_enable && !clock_ctrl.periph_div_run;
  endproperty
  a_low_off: assert property (p_low_off)
    else $error("high clocks on in slow mode");
  property p_fast_wake;
    power_state == st_wake && clock_ctrl.cpu_run |-> clock_ctrl.src != src_off
      && mode_reg[`FAST_WAKE_BIT] && !from_s0_reg
      && osc_option.high_kind == high_speed_crystal;
  endproperty
  a_fast_wake: assert property (p_fast_wake)
    else $error("cpu run during wait");
  c_idle_1_mode: cover property (power_state == st_idle_1_mode);
  c_fast: cover property (power_state == st_wake && clock_ctrl.cpu_run);
  c_slow: cover property (power_state == st_run && clock_ctrl.src == src_low);
endmodule
bind clock_mode_ctrl clock_mode_ctrl_props clock_mode_ctrl_props_i (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .halt_req(halt_req), .wake_req(wake_req), .sub_keep_on(sub_keep_on),
  .osc_option(osc_option), .high_osc_tick(high_osc_tick),
  .low_osc_tick(low_osc_tick), .clock_ctrl(clock_ctrl),
  .power_state(power_state), .irq(irq));
`default_nettype wire

/* File: osc_model.sv */
// oscillator model: ticks only while its enable is high
`timescale 1ns/10ps
`default_nettype none
module osc_model #(
  parameter int LOW_DIV = 3
) (
  // clock
  input wire logic clk,
  // enables
  input wire logic high_en,
  input wire logic low_en,
  // ticks
  output var logic high_tick,
  output var logic low_tick
);
  int cnt = 0;
  always @(posedge clk) begin
    cnt <= cnt + 1;
    high_tick <= high_en;
    low_tick <= low_en && (cnt % LOW_DIV == 0);
  end
endmodule
`default_nettype wire

/* File: clock_mode_ctrl_tb.sv */
// self-checking bench for the clock mode controller
`timescale 1ns/10ps
`default_nettype none
`include "clock_mode_params.svh"
module clock_mode_ctrl_tb;
  import clock_mode_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic halt_req = 1'h0;
  logic wake_req = 1'h0;
  logic sub_keep_on = 1'h0;
  osc_option_type osc_option = '{high_speed_crystal, low_speed_internal_rc};
  logic high_osc_tick, low_osc_tick, irq;
  logic [7:0] reg_rdata;
  clock_ctrl_type clock_ctrl;
  power_state_type power_state;
  int n_fail = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'h514d;
  always #2 clk = ~clk;
  clock_mode_ctrl clock_mode_ctrl_i (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_req(halt_req),
    .wake_req(wake_req), .sub_keep_on(sub_keep_on), .osc_option(osc_option),
    .high_osc_tick(high_osc_tick), .low_osc_tick(low_osc_tick),
    .clock_ctrl(clock_ctrl), .power_state(power_state), .irq(irq));
  osc_model osc_model_i (.clk(clk), .high_en(clock_ctrl.high_osc_enable),
    .low_en(clock_ctrl.low_osc_enable), .high_tick(high_osc_tick),
    .low_tick(low_osc_tick));
  // ====
  // expectations
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic power_state_type halt_exp(input logic [2:0] m);
    if (m[0]) return m[1] ? st_idle_1_mode : st_idle_0_mode;
    return m[1] ? st_sleep_1_mode : st_sleep_0_mode;
  endfunction
  // substitute clock only from sleep-1 or idle-0, crystal only
  function automatic logic fast_exp(input logic [2:0] m, input int k);
    return m[2] && k == 0 && (m[0] ^ m[1]);
  endfunction
  function automatic int wake_exp(input logic [2:0] m, input int k);
    if (m[0] && m[1]) return 0;
    return k ? 16 : 1024;
  endfunction
  // ====
  // bus tasks and compare
  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    results();
  end
  // ====
  // scenarios, crystal, then internal rc, then external rc
  initial begin
    logic [7:0] d, w;
    logic [2:0] m;
    logic seen;
    int c;
    for (int k = 0; k < 3; k++) begin
      osc_option.high_kind <= (k == 0) ? high_speed_crystal :
                              (k == 1) ? high_speed_internal_rc : external_rc;
      rst <= 1'h1;
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      d = 8'h00;
      c = 0;
      while (d[2] !== 1'h1 && c < 2000) begin
        rd(`ADDR_MODE_CTRL, d);
        c++;
      end
      chk("mode after power-on", d, 8'h0f);
      rd(`ADDR_AUX_CTRL, d);
      chk("aux reset", d, 8'h00);
      rd(`ADDR_IRQ_STATUS, d);
      chk("ready events", d, 8'h03);
      wr(`ADDR_IRQ_MASK, 8'h01);
      settle(3);
      chk("irq raised", irq, 1'h1);
      wr(`ADDR_IRQ_STATUS, 8'h01);
      settle(3);
      chk("irq cleared", irq, 1'h0);
      rd(`ADDR_IRQ_STATUS, d);
      chk("status after clear", d, 8'h02);
      repeat (4) begin
        seed = xs(seed);
        w = seed[7:0] | 8'h01;
        wr(`ADDR_MODE_CTRL, w);
        rd(`ADDR_MODE_CTRL, d);
        chk("mode readback", d, (w & `WRITABLE_MASK) | 8'h0c);
      end
      for (int code = 2; code < 8; code++) begin
        wr(`ADDR_MODE_CTRL, {code[2:0], 5'h00});
        settle(3);
        chk("divided source", clock_ctrl.src, src_high_div);
        chk("divider code", clock_ctrl.div_code, code[2:0]);
      end
      wr(`ADDR_MODE_CTRL, 8'h02);
      c = 0;
      while (clock_ctrl.src !== src_low && c < 100) begin
        settle(1);
        c++;
      end
      settle(3);
      chk("slow source", clock_ctrl.src, src_low);
      chk("high osc off", clock_ctrl.high_osc_enable, 1'h0);
      chk("divided clocks off", clock_ctrl.periph_div_run, 1'h0);
      wr(`ADDR_MODE_CTRL, 8'h03);
      c = 0;
      while (clock_ctrl.src !== src_high && c < 3000) begin
        settle(1);
        c++;
      end
      chk("back to high", clock_ctrl.src, src_high);
      for (int i = 0; i < 8; i++) begin
        m = i[2:0];
        wr(`ADDR_AUX_CTRL, {7'h00, m[1]});
        wr(`ADDR_MODE_CTRL, {3'h0, m[2], 2'h0, m[0], 1'h1});
        @(posedge clk);
        sub_keep_on <= m[1];
        halt_req <= 1'h1;
        @(posedge clk);
        halt_req <= 1'h0;
        settle(6);
        chk("halt mode", power_state, halt_exp(m));
        chk("low osc asleep", clock_ctrl.low_osc_enable, m[0] | m[1]);
        rd(`ADDR_MODE_CTRL, d);
        chk("low ready asleep", d[3], m[0] | m[1]);
        chk("high ready asleep", d[2], m[0] & m[1]);
        @(posedge clk);
        wake_req <= 1'h1;
        @(posedge clk);
        wake_req <= 1'h0;
        #1;
        c = 0;
        seen = 1'h0;
        while (power_state !== st_run && c < 3000) begin
          settle(1);
          seen = seen | (power_state === st_wake && clock_ctrl.cpu_run);
          c++;
        end
        chk("fast wake", seen, fast_exp(m, k));
        chk("wake time", c >= wake_exp(m, k) && c <= wake_exp(m, k) + 8,
            1'h1);
      end
      rd(`ADDR_IRQ_STATUS, d);
      chk("wake event", d[2], 1'h1);
      $display("phase %0d done", k);
    end
    results();
  end
endmodule
`default_nettype wire
